/* File: spisr_pkg.sv */
// package for the serial peripheral status, control and data registers
package spisr_pkg;

    // =========================================================
    // register offsets (byte addresses, AXI4-Lite word aligned)
    localparam int REG_IDX_DATA = 8'h21;
    localparam int REG_IDX_CTRL = 8'h22;
    localparam int REG_IDX_CSR = 8'h23;
    localparam logic [11:0] ADDR_DATA = 12'h084;
    localparam logic [11:0] ADDR_CTRL = 12'h088;
    localparam logic [11:0] ADDR_CSR = 12'h08C;

    // =========================================================
    // control register fields
    localparam int CR_IRQ_EN = 7;
    localparam int CR_PER_EN = 6;
    localparam int CR_DIV2 = 5;
    localparam int CR_MASTER = 4;
    localparam int CR_CLOCK_IDLE_LEVEL_BIT = 3;
    localparam int CR_CLOCK_CAPTURE_EDGE_BIT = 2;
    localparam int CR_RATE1 = 1;
    localparam int CR_RATE0 = 0;

    // status register fields
    localparam int SR_DONE = 7;
    localparam int SR_WRITE_COLLISION_FLAG = 6;
    localparam int SR_OVR = 5;
    localparam int SR_MASTER_FAULT_FLAG = 4;
    localparam int SR_OUT_DIS = 2;
    localparam int SR_SOFT_SEL = 1;
    localparam int SR_INT_SEL = 0;
    localparam logic [7:0] SR_SW_MASK = 8'h07;

    localparam logic [7:0] CR_RESET = 8'h00;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [3:0] BIT_COUNT = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SPISR_IDLE,
        SPISR_RUN
    } spisr_state_t;

    // serial pins as they leave the block
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } spisr_pins_t;

endpackage

/* File: spisr_top.sv */
// serial peripheral: status, control and data registers with the shift engine
`timescale 1ns/1ps
// =========================================================
// Overview of operation
// - set done flag when a byte finishes; interrupt if enabled
// - done flag clears after status read then data read or write
// - data writes ignored while done flag set until status read
// - data write during transfer sets read-only write collision flag
// - overrun flag set when byte arrives while done flag still set
// - status register read clears overrun flag
// - select low while master sets mode fault flag; may interrupt
// - mode fault clears on control access while set, then control write
// - output disable releases MOSI as master, MISO as slave; else drive if enabled, MISO only while selected
// - soft select management ignores select pin, uses internal select bit
// - internal select bit 0 selects, 1 deselects
// - master: data register write starts one byte transfer
// - final cycle of transfer copies shift register into receive buffer unless done flag still set
// - data register read returns receive buffer, not shift register
// - data written goes straight into the shift register
// - data, control, status registers at consecutive addresses
// - status register clears to zero on reset
// - interrupt when enabled and done, fault or overrun flag set
// - master fault clears peripheral enable and master select
// - phase 0 captures on first edge, phase 1 on second
module spisr_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial pins
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    input wire logic ss_n_i,
    output spisr_pkg::spisr_pins_t pins,
    // interrupt request
    output logic irq
);
    import spisr_pkg::*;

    // =========================================================
    // pin synchronisers
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // idle levels of the pins at reset: clock low, data don't care, select high
            sync1_r <= 4'h1;
            sync2_r <= 4'h1;
        end else begin
            sync1_r <= {sck_i, mosi_i, miso_i, ss_n_i};
            sync2_r <= sync1_r;
        end
    end
    logic sck_s, mosi_s, miso_s, ss_n_s;
    assign {sck_s, mosi_s, miso_s, ss_n_s} = sync2_r;

    // =========================================================
    // registers
    logic [7:0] ctrl_r;
    logic [7:0] csr_r;
    logic [7:0] rxbuf_r;
    logic [7:0] shift_r;

    logic en, master, clock_idle_level_bit, clock_capture_edge_bit;
    assign en = ctrl_r[CR_PER_EN];
    assign master = ctrl_r[CR_MASTER];
    assign clock_idle_level_bit = ctrl_r[CR_CLOCK_IDLE_LEVEL_BIT];
    assign clock_capture_edge_bit = ctrl_r[CR_CLOCK_CAPTURE_EDGE_BIT];

    // effective select level, low active
    logic sel_n;
    assign sel_n = csr_r[SR_SOFT_SEL] ? csr_r[SR_INT_SEL] : ss_n_s;

    // =========================================================
    // axi4-lite slave: one access of each kind at a time
    logic aw_held_r, w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (aw_held_r && w_held_r) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
        end
    end

    logic wr_go;
    assign wr_go = aw_held_r && w_held_r;
    logic wr_data, wr_ctrl, wr_csr, wr_known;
    assign wr_known = (awaddr_r[11:2] == ADDR_DATA[11:2]) || (awaddr_r[11:2] == ADDR_CTRL[11:2])
        || (awaddr_r[11:2] == ADDR_CSR[11:2]);
    assign wr_data = wr_go && wstrb_r[0] && (awaddr_r[11:2] == ADDR_DATA[11:2]);
    assign wr_ctrl = wr_go && wstrb_r[0] && (awaddr_r[11:2] == ADDR_CTRL[11:2]);
    assign wr_csr = wr_go && wstrb_r[0] && (awaddr_r[11:2] == ADDR_CSR[11:2]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read: address taken, data answers on the next edge
    logic rd_data, rd_ctrl, rd_csr, rd_go;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign rd_data = rd_go && (s_axi_araddr[11:2] == ADDR_DATA[11:2]);
    assign rd_ctrl = rd_go && (s_axi_araddr[11:2] == ADDR_CTRL[11:2]);
    assign rd_csr = rd_go && (s_axi_araddr[11:2] == ADDR_CSR[11:2]);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (rd_data || rd_ctrl || rd_csr) ? RESP_OKAY : RESP_SLVERR;
            if (rd_data) begin
                s_axi_rdata <= {24'h000000, rxbuf_r};
            end else if (rd_ctrl) begin
                s_axi_rdata <= {24'h000000, ctrl_r};
            end else if (rd_csr) begin
                s_axi_rdata <= {24'h000000, csr_r};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // =========================================================
    // clear sequences: status access arms, data access completes; for mode fault, control access arms, control write completes
    logic csr_seen_r, master_fault_flag_seen_r;
    logic csr_access, ctrl_access;
    assign csr_access = rd_csr || wr_csr;
    assign ctrl_access = rd_ctrl || wr_ctrl;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csr_seen_r <= 1'b0;
        end else if (csr_access) begin
            csr_seen_r <= 1'b1;
        end else if (rd_data || wr_data) begin
            csr_seen_r <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_fault_flag_seen_r <= 1'b0;
        end else if (ctrl_access && csr_r[SR_MASTER_FAULT_FLAG]) begin
            master_fault_flag_seen_r <= 1'b1;
        end else if (wr_ctrl) begin
            master_fault_flag_seen_r <= 1'b0;
        end
    end

    // =========================================================
    // shift engine
    spisr_state_t state_r;
    logic [3:0] bits_r;
    logic [6:0] div_r;
    logic sck_r, sck_d_r;
    logic [6:0] half_cnt;
    logic start, done_evt, busy, sample_bit;

    // half period of serial clock in cpu cycles, minus one
    always_comb begin
        case ({ctrl_r[CR_DIV2], ctrl_r[CR_RATE1], ctrl_r[CR_RATE0]})
            3'h4: half_cnt = 7'h01;
            3'h0: half_cnt = 7'h03;
            3'h1: half_cnt = 7'h07;
            3'h6: half_cnt = 7'h0F;
            3'h2: half_cnt = 7'h1F;
            3'h3: half_cnt = 7'h3F;
            default: half_cnt = 7'h03;
        endcase
    end

    // data writes inhibited while done flag stands and status unread
    logic wr_data_ok;
    assign wr_data_ok = wr_data && !(csr_r[SR_DONE] && !csr_seen_r);
    assign busy = (state_r == SPISR_RUN);
    assign start = wr_data_ok && !busy && en && master;

    // slave edge detect on synchronised clock
    logic sck_prev_r;
    logic slv_lead, slv_trail;
    assign slv_lead = (sck_s != sck_prev_r) && (sck_s != clock_idle_level_bit);
    assign slv_trail = (sck_s != sck_prev_r) && (sck_s == clock_idle_level_bit);

    // master edges from the divider
    logic m_tick, m_lead, m_trail;
    assign m_tick = busy && master && (div_r == half_cnt);
    assign m_lead = m_tick && (sck_r == clock_idle_level_bit);
    assign m_trail = m_tick && (sck_r != clock_idle_level_bit);

    logic lead, trail, rx_in;
    assign lead = master ? m_lead : (slv_lead && !sel_n);
    assign trail = master ? m_trail : (slv_trail && !sel_n);
    assign rx_in = master ? miso_s : mosi_s;
    // phase 0 samples on the leading edge, phase 1 on the trailing one
    assign sample_bit = clock_capture_edge_bit ? trail : lead;
    logic shift_bit;
    assign shift_bit = clock_capture_edge_bit ? lead : trail;
    assign done_evt = busy && sample_bit && (bits_r == BIT_COUNT - 4'h1);

    logic out_bit_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= SPISR_IDLE;
            bits_r <= 4'h0;
            div_r <= 7'h00;
            sck_r <= 1'b0;
            sck_prev_r <= 1'b0;
            shift_r <= 8'h00;
            out_bit_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_s;
            if (!busy) begin
                sck_r <= clock_idle_level_bit;
            end
            case (state_r)
                SPISR_IDLE: begin
                    div_r <= 7'h00;
                    bits_r <= 4'h0;
                    // between frames the msb stands on the output, ready for the first edge
                    if (wr_data_ok) begin
                        shift_r <= wstrb_r[0] ? wdata_r[7:0] : shift_r;
                        out_bit_r <= wdata_r[7];
                    end else begin
                        out_bit_r <= shift_r[7];
                    end
                    // a slave frame opens on a leading edge only: the trailing edge
                    // that closes the last bit must not start a phantom frame
                    if (start || (en && !master && !sel_n && wr_data_ok == 1'b0 &&
                            slv_lead)) begin
                        state_r <= SPISR_RUN;
                    end
                    if (en && !master && !sel_n && !clock_capture_edge_bit && slv_lead) begin
                        shift_r <= {shift_r[6:0], rx_in};
                        bits_r <= 4'h1;
                    end
                end
                SPISR_RUN: begin
                    if (m_tick) begin
                        div_r <= 7'h00;
                        sck_r <= !sck_r;
                    end else if (master) begin
                        div_r <= div_r + 7'h01;
                    end
                    if (sample_bit) begin
                        shift_r <= {shift_r[6:0], rx_in};
                        bits_r <= bits_r + 4'h1;
                    end
                    if (shift_bit && !(clock_capture_edge_bit == 1'b0 && bits_r == 4'h0)) begin
                        out_bit_r <= shift_r[7];
                    end else if (shift_bit && clock_capture_edge_bit && bits_r == 4'h0) begin
                        out_bit_r <= shift_r[7];
                    end
                    if (done_evt || !en || (!master && sel_n)) begin
                        state_r <= SPISR_IDLE;
                    end
                end
                default: state_r <= SPISR_IDLE;
            endcase
        end
    end

    // receive buffer: loaded at the end unless the done flag is still set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxbuf_r <= 8'h00;
        end else if (done_evt && !csr_r[SR_DONE]) begin
            rxbuf_r <= {shift_r[6:0], rx_in};
        end
    end

    // =========================================================
    // mode fault and control register
    logic fault_evt;
    assign fault_evt = en && master && !sel_n;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CR_RESET;
        end else if (fault_evt) begin
            ctrl_r[CR_PER_EN] <= 1'b0;
            ctrl_r[CR_MASTER] <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_r <= wdata_r[7:0];
        end
    end

    // status register: hardware set wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csr_r <= CSR_RESET;
        end else begin
            if (done_evt) begin
                csr_r[SR_DONE] <= 1'b1;
            end else if (csr_seen_r && (rd_data || wr_data)) begin
                csr_r[SR_DONE] <= 1'b0;
            end
            if (wr_data && busy) begin
                csr_r[SR_WRITE_COLLISION_FLAG] <= 1'b1;
            end else if (csr_seen_r && (rd_data || wr_data)) begin
                csr_r[SR_WRITE_COLLISION_FLAG] <= 1'b0;
            end
            if (done_evt && csr_r[SR_DONE]) begin
                csr_r[SR_OVR] <= 1'b1;
            end else if (rd_csr) begin
                csr_r[SR_OVR] <= 1'b0;
            end
            if (fault_evt) begin
                csr_r[SR_MASTER_FAULT_FLAG] <= 1'b1;
            end else if (master_fault_flag_seen_r && wr_ctrl) begin
                csr_r[SR_MASTER_FAULT_FLAG] <= 1'b0;
            end
            csr_r[3] <= 1'b0;
            if (wr_csr) begin
                csr_r[2:0] <= wdata_r[2:0] & SR_SW_MASK[2:0];
            end
        end
    end

    assign irq = ctrl_r[CR_IRQ_EN] && (csr_r[SR_DONE] || csr_r[SR_OVR] || csr_r[SR_MASTER_FAULT_FLAG]);

    // =========================================================
    // pin drive
    logic out_ok;
    assign out_ok = en && !csr_r[SR_OUT_DIS];
    always_comb begin
        pins.sck_o = sck_r;
        pins.sck_oe = en && master;
        pins.mosi_o = out_bit_r;
        pins.mosi_oe = out_ok && master;
        pins.miso_o = out_bit_r;
        pins.miso_oe = out_ok && !master && !sel_n;
    end

endmodule

/* File: spisr_sva.sv */
// checker for the serial register block, bound to its top module
`timescale 1ns/1ps
module spisr_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial pins and interrupt
    input wire spisr_pkg::spisr_pins_t pins,
    input wire logic irq
);
    import spisr_pkg::*;
    // =========================================================
    // helper: address of the read under way
    logic [11:0] rd_addr_r;
    logic mapped;
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_r <= s_axi_araddr;
        end
    end
    assign mapped = rd_addr_r == ADDR_DATA || rd_addr_r == ADDR_CTRL || rd_addr_r == ADDR_CSR;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence both_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // =========================================================
    // properties
    reset_clear_a: assert property (
        $rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid && !pins.sck_oe
            && !pins.mosi_oe && !pins.miso_oe) else $error("outputs active after reset");
    write_resp_a: assert property (both_taken_s |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    bvalid_hold_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
        else $error("write response dropped");
    rvalid_hold_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
        else $error("read response dropped");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
        && !(rd_addr_r == ADDR_CSR && s_axi_rdata[3])) else $error("unused bits set");
    addr_decode_a: assert property (
        s_axi_rvalid |-> ((s_axi_rresp == RESP_OKAY) == mapped)
            && (mapped || s_axi_rdata == 32'h0)) else $error("bad decode");
    out_release_a: assert property (
        !(pins.mosi_oe && pins.miso_oe) && (!pins.mosi_oe || pins.sck_oe))
        else $error("both outputs driven");
endmodule

bind spisr_top spisr_chk spisr_chk_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pins(pins), .irq(irq)
);

/* File: spisr_master_model.sv */
// external serial master that exchanges bytes with the block
`timescale 1ns/1ps
module spisr_master_model (
    // serial lines
    output logic sck,
    output logic mosi,
    output logic ss_n,
    input wire logic miso
);
    localparam realtime HALF = 62.5;
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
    end
    // =========================================================
    // one byte, msb first; clock idles low and stands still between frames
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        ss_n = 1'b0;
        mosi = tx[7];
        #HALF;
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b1;
            rx[i] = miso;
            #HALF;
            sck = 1'b0;
            mosi = (i > 0) ? tx[i - 1] : ~mosi;
            #HALF;
        end
        ss_n = 1'b1;
    endtask
    // select pulled low with no clock: a fault for a master
    task automatic select_pulse();
        ss_n = 1'b0;
        #101;
        ss_n = 1'b1;
    endtask
endmodule

/* File: tb_top.sv */
// testbench for the serial register block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
    import spisr_pkg::*;
    logic aclk, aresetn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic sck, mosi, ss_n, miso_m, miso_s, irq;
    logic [7:0] rx;
    spisr_pins_t pins;
    int num_errors, total_checks, cycles;
    always #2 aclk = ~aclk;
    // a released line shows the inverse of its last level
    assign miso_m = pins.mosi_oe ? pins.mosi_o : ~pins.mosi_o;
    assign miso_s = pins.miso_oe ? pins.miso_o : ~pins.miso_o;
    spisr_top spisr_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sck_i(sck), .mosi_i(mosi), .miso_i(miso_m), .ss_n_i(ss_n),
        .pins(pins), .irq(irq));
    spisr_master_model spisr_master_model_i (.sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso_s));
    // =========================================================
    // bus tasks
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        `CHK(s_axi_bresp, RESP_OKAY)
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (!s_axi_arready) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        while (!s_axi_rvalid) @(posedge aclk);
        v = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] v;
        logic [1:0] rr;
        rd(a, v, rr);
        `CHK(v, {24'h0, e})
        `CHK(rr, RESP_OKAY)
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // a run takes about two thousand cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    // =========================================================
    // tests
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk(ADDR_CSR, CSR_RESET);
        rd(12'h090, d, r);
        `CHK(r, RESP_SLVERR)
        `CHK(d, 32'h0)
        wr(ADDR_CSR, 8'h07);
        wr(ADDR_CTRL, 8'h0C);
        rdchk(ADDR_CTRL, 8'h0C);
        rdchk(ADDR_CSR, 8'h07);
        // slave, select from the pin, interrupts on
        wr(ADDR_CSR, 8'h00);
        wr(ADDR_CTRL, 8'hC0);
        wr(ADDR_DATA, 8'h3C);
        spisr_master_model_i.xfer(8'hA5, rx);
        `CHK(rx, 8'h3C)
        `CHK(irq, 1'b1)
        rdchk(ADDR_CSR, 8'h80);
        rdchk(ADDR_DATA, 8'hA5);
        `CHK(irq, 1'b0)
        rdchk(ADDR_CSR, 8'h00);
        rdchk(ADDR_DATA, 8'hA5);
        // second byte lands before the flag is cleared
        spisr_master_model_i.xfer(8'h11, rx);
        wr(ADDR_DATA, 8'h77);
        spisr_master_model_i.xfer(8'h22, rx);
        `CHK(rx, 8'h11)
        rdchk(ADDR_CSR, 8'hA0);
        rdchk(ADDR_CSR, 8'h80);
        rdchk(ADDR_DATA, 8'h11);
        // software select: pin ignored, internal bit decides
        wr(ADDR_CSR, 8'h03);
        spisr_master_model_i.xfer(8'h5C, rx);
        rdchk(ADDR_CSR, 8'h03);
        wr(ADDR_CSR, 8'h06);
        `CHK(pins.miso_oe, 1'b0)
        wr(ADDR_CSR, 8'h02);
        `CHK(pins.miso_oe, 1'b1)
        spisr_master_model_i.xfer(8'h5C, rx);
        rdchk(ADDR_CSR, 8'h82);
        rdchk(ADDR_DATA, 8'h5C);
        // master at a 32nd of the clock, looped back on itself
        wr(ADDR_CSR, 8'h00);
        wr(ADDR_CTRL, 8'hF2);
        `CHK(pins.sck_o, 1'b0)
        `CHK(pins.mosi_oe, 1'b1)
        wr(ADDR_DATA, 8'h5A);
        wr(ADDR_DATA, 8'h33);
        d = 32'h0;
        for (int i = 0; i < 200 && d[7] !== 1'b1; i++) begin
            rd(ADDR_CSR, d, r);
        end
        `CHK(d[7:0], 8'hC0)
        rdchk(ADDR_DATA, 8'h5A);
        rdchk(ADDR_CSR, 8'h00);
        // select pulled low under an enabled master
        spisr_master_model_i.select_pulse();
        `CHK(irq, 1'b1)
        `CHK(pins.sck_oe, 1'b0)
        rdchk(ADDR_CSR, 8'h10);
        rdchk(ADDR_CTRL, 8'hA2);
        wr(ADDR_CTRL, 8'h00);
        rdchk(ADDR_CSR, 8'h00);
        `CHK(irq, 1'b0)
        // master at an 8th of the clock, idle high, capture on the second edge
        wr(ADDR_CTRL, 8'h5C);
        wr(ADDR_DATA, 8'hC3);
        d = 32'h0;
        for (int i = 0; i < 200 && d[7] !== 1'b1; i++) begin
            rd(ADDR_CSR, d, r);
        end
        `CHK(d[7:0], 8'h80)
        `CHK(pins.sck_o, 1'b1)
        rdchk(ADDR_DATA, 8'hC3);
        end_of_test();
    end
endmodule
